/* logic/imu_system_tools_regs.sv */
// System-tool register bank: commands, I/O lines, flags, identity words.
`timescale 1ns/10ps

module imu_system_tools_regs
	import imu_tools_pkg::*;
#(
	parameter int          RESET_CYCLES = RESET_TIME_MS * CLK_KHZ,
	// Identity words; the values are arbitrary.
	parameter logic [15:0] LOT_FIRST    = 16'h1111,
	parameter logic [15:0] LOT_SECOND   = 16'h2222,
	parameter logic [15:0] PRODUCT      = 16'h0001,
	parameter logic [15:0] SERIAL       = 16'h0042
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire reg_req_t    i_req,
	output logic      [15:0] o_rdata,
	input  wire logic  [3:0] i_io_in,
	output logic       [3:0] o_io_out,
	output logic       [3:0] o_io_oe,
	input  wire logic        i_data_ready,
	input  wire logic        i_sample_tick,
	input  wire logic  [2:0] i_alarm_indicator,
	input  wire logic  [1:0] i_alarm_active,
	input  wire cmd_t        i_done,
	input  wire logic  [5:0] i_selftest_fail,
	input  wire logic        i_selftest_error,
	input  wire logic        i_checksum_fail,
	input  wire logic        i_overrange,
	input  wire logic        i_link_fail,
	input  wire logic        i_flash_update_fail,
	input  wire logic        i_flash_write,
	output cmd_t             o_busy,
	output logic             o_soft_reset,
	output logic             o_lin_comp,
	output logic             o_accel_align
);

	localparam logic [19:0] RESET_LAST = 20'(RESET_CYCLES - 1);

	state_t      st;
	state_t      next_st;
	logic [15:0] next_diag_set;
	logic [3:0]  drive;
	logic [3:0]  level;
	logic        dr_level;
	logic        al_level;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_diag_set = '0;

		// Pin inputs pass three flops; a change counts once the
		// second and third agree.
		next_st.pin_s1 = i_io_in;
		next_st.pin_s2 = st.pin_s1;
		next_st.pin_s3 = st.pin_s2;
		for (int i = 0; i < 4; i++) begin
			if (st.pin_s2[i] == st.pin_s3[i]) begin
				next_st.pin[i] = st.pin_s3[i];
			end
		end

		// Register reads; the value is captured before any clear.
		if (i_req.rd) begin
			case (i_req.addr)
				ADDR_FLASH_COUNT: next_st.rdata = st.flash_count;
				ADDR_IO_LINE: begin
					next_st.rdata = st.io_line;
					for (int i = 0; i < 4; i++) begin
						if (!st.io_line[IO_DIR_LSB + i]) begin
							next_st.rdata[IO_LEVEL_LSB + i] =
								st.pin[i];
						end
					end
				end
				ADDR_MISC:       next_st.rdata = st.misc;
				ADDR_DIAG:       next_st.rdata = st.diag;
				ADDR_LOT_FIRST:  next_st.rdata = LOT_FIRST;
				ADDR_LOT_SECOND: next_st.rdata = LOT_SECOND;
				ADDR_PRODUCT:    next_st.rdata = PRODUCT;
				ADDR_SERIAL:     next_st.rdata = SERIAL;
				default:         next_st.rdata = '0;
			endcase
		end

		// Finished functions clear their own bits.
		if (i_done.backup) begin
			next_st.cmd[CMD_BACKUP] = 1'b0;
		end
		if (i_done.restore) begin
			next_st.cmd[CMD_RESTORE] = 1'b0;
		end
		if (i_done.autonull) begin
			next_st.cmd[CMD_AUTONULL] = 1'b0;
		end
		if (i_done.selftest) begin
			next_st.misc[MISC_SELFTEST] = 1'b0;
			next_diag_set[DIAG_SELFTEST_LSB +: 6] = i_selftest_fail;
			next_diag_set[DIAG_TEST_ERR] = i_selftest_error;
		end
		if (i_done.memtest) begin
			next_st.misc[MISC_MEMTEST] = 1'b0;
			next_diag_set[DIAG_CHECKSUM] = i_checksum_fail;
		end

		// Register writes, unused bits masked away. They come after the
		// clears, so a command written as its last run ends still starts.
		if (i_req.wr && st.phase == RUNNING) begin
			case (i_req.addr)
				ADDR_IO_LINE: begin
					next_st.io_line = i_req.wdata & IO_LINE_MASK;
				end
				ADDR_MISC: begin
					next_st.misc = i_req.wdata & MISC_MASK;
				end
				ADDR_GLOBAL_CMD: begin
					next_st.cmd = i_req.wdata & CMD_MASK;
				end
				default: begin
				end
			endcase
		end

		// Persisting conditions set again on each sample cycle.
		if (i_sample_tick) begin
			next_diag_set[DIAG_ALARM_LSB +: 2] = i_alarm_active;
			next_diag_set[DIAG_OVERRANGE] = i_overrange;
			next_diag_set[DIAG_LINK_FAIL] = i_link_fail;
			next_diag_set[DIAG_FLASH_FAIL] = i_flash_update_fail;
		end

		// A read clears every flag; a flag set in that cycle wins.
		if (i_req.rd && i_req.addr == ADDR_DIAG) begin
			next_st.diag = '0;
		end
		next_st.diag = (next_st.diag | next_diag_set) & DIAG_MASK;

		if (i_flash_write) begin
			next_st.flash_count = st.flash_count + 16'h0001;
		end

		// Software reset sequence.
		case (st.phase)
			RUNNING: begin
				if (next_st.cmd[CMD_SWRESET]) begin
					next_st.phase = RESETTING;
					next_st.reset_count = '0;
				end
			end
			RESETTING: begin
				if (st.reset_count == RESET_LAST) begin
					next_st.phase = RUNNING;
					next_st.cmd = '0;
					next_st.io_line = IO_LINE_RESET;
					next_st.misc = MISC_RESET;
				end else begin
					next_st.reset_count = st.reset_count + 20'h00001;
				end
			end
			default: begin
				next_st.phase = RUNNING;
			end
		endcase
		next_st.soft_reset = (next_st.phase == RESETTING);

		next_st.busy.backup = next_st.cmd[CMD_BACKUP];
		next_st.busy.restore = next_st.cmd[CMD_RESTORE];
		next_st.busy.autonull = next_st.cmd[CMD_AUTONULL];
		next_st.busy.selftest = next_st.misc[MISC_SELFTEST];
		next_st.busy.memtest = next_st.misc[MISC_MEMTEST];

		// Line drivers: data ready first, then alarm, then I/O bits.
		dr_level = next_st.misc[MISC_DR_POL] ? i_data_ready
			: !i_data_ready;
		al_level = i_alarm_indicator[ALARM_IND_POL] ? |i_alarm_active
			: !(|i_alarm_active);
		drive = next_st.io_line[IO_DIR_LSB +: 4];
		level = next_st.io_line[IO_LEVEL_LSB +: 4];
		if (i_alarm_indicator[ALARM_IND_EN]) begin
			drive[i_alarm_indicator[ALARM_IND_LINE]] = 1'b1;
			level[i_alarm_indicator[ALARM_IND_LINE]] = al_level;
		end
		if (next_st.misc[MISC_DR_EN]) begin
			drive[next_st.misc[MISC_DR_LINE]] = 1'b1;
			level[next_st.misc[MISC_DR_LINE]] = dr_level;
		end
		next_st.io_oe = drive;
		next_st.io_out = level & drive;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st <= '{
				phase:       RUNNING,
				reset_count: '0,
				cmd:         '0,
				io_line:     IO_LINE_RESET,
				misc:        MISC_RESET,
				diag:        DIAG_RESET,
				flash_count: '0,
				rdata:       '0,
				pin_s1:      '0,
				pin_s2:      '0,
				pin_s3:      '0,
				pin:         '0,
				io_out:      '0,
				io_oe:       '0,
				soft_reset:  1'b0,
				busy:        '0
			};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rdata       = st.rdata;
	assign o_io_out      = st.io_out;
	assign o_io_oe       = st.io_oe;
	assign o_busy        = st.busy;
	assign o_soft_reset  = st.soft_reset;
	assign o_lin_comp    = st.misc[MISC_LINCOMP];
	assign o_accel_align = st.misc[MISC_ALIGN];

endmodule

/* pkg/imu_tools_pkg.sv */
// Constants, types and state layout of the system-tool register bank.
//
// Summary of operation
// - Command bits start on one, self-clear when done.
// - Command bit 7 resets device for 60 ms.
// - Bits 3, 1, 0: back-up, restore, auto-null.
// - Line function priority: misc, alarm, then I/O.
// - I/O bits 0 to 3 set line directions.
// - I/O bits 8 to 11 hold line levels.
// - Data-ready defaults active high on line 1.
// - Misc bits 2,1,0: enable, polarity, line select.
// - Misc bits 7 and 6 enable compensations.
// - Misc bit 10 runs self-test, then self-clears.
// - Misc bit 11 runs checksum into flag 6.
// - Reading the diagnostic flags clears them all.
// - Persisting conditions set again next sample cycle.
// - Flags 15-13 accel, 12-10 gyro self-test failures.
// - Flags 9 and 8 show alarms 2 and 1.
// - Flags 6-2: checksum, test, range, link, flash.
// - Lot, product and serial words read as constants.
// - Flash write counter counts every flash write.
// - Restore clears calibration, flash updated within 50 ms.
// - Auto-null negates gyro readings into offsets, backs up.
package imu_tools_pkg;

	localparam logic [6:0] ADDR_FLASH_COUNT = 7'h00;
	localparam logic [6:0] ADDR_IO_LINE     = 7'h32;
	localparam logic [6:0] ADDR_MISC        = 7'h34;
	localparam logic [6:0] ADDR_DIAG        = 7'h3C;
	localparam logic [6:0] ADDR_GLOBAL_CMD  = 7'h3E;
	localparam logic [6:0] ADDR_LOT_FIRST   = 7'h52;
	localparam logic [6:0] ADDR_LOT_SECOND  = 7'h54;
	localparam logic [6:0] ADDR_PRODUCT     = 7'h56;
	localparam logic [6:0] ADDR_SERIAL      = 7'h58;

	localparam logic [15:0] IO_LINE_RESET = 16'h0000;
	localparam logic [15:0] MISC_RESET    = 16'h0006;
	localparam logic [15:0] DIAG_RESET    = 16'h0000;

	localparam logic [15:0] CMD_MASK     = 16'h008B;
	localparam logic [15:0] MISC_MASK    = 16'h0CC7;
	localparam logic [15:0] DIAG_MASK    = 16'hFF7C;
	localparam logic [15:0] IO_LINE_MASK = 16'h0F0F;

	localparam int CMD_SWRESET  = 7;
	localparam int CMD_BACKUP   = 3;
	localparam int CMD_RESTORE  = 1;
	localparam int CMD_AUTONULL = 0;

	localparam int MISC_MEMTEST  = 11;
	localparam int MISC_SELFTEST = 10;
	localparam int MISC_LINCOMP  = 7;
	localparam int MISC_ALIGN    = 6;
	localparam int MISC_DR_EN    = 2;
	localparam int MISC_DR_POL   = 1;
	localparam int MISC_DR_LINE  = 0;

	localparam int IO_DIR_LSB   = 0;
	localparam int IO_LEVEL_LSB = 8;

	localparam int DIAG_SELFTEST_LSB = 10;
	localparam int DIAG_ALARM_LSB    = 8;
	localparam int DIAG_CHECKSUM     = 6;
	localparam int DIAG_TEST_ERR     = 5;
	localparam int DIAG_OVERRANGE    = 4;
	localparam int DIAG_LINK_FAIL    = 3;
	localparam int DIAG_FLASH_FAIL   = 2;

	localparam int ALARM_IND_EN   = 2;
	localparam int ALARM_IND_POL  = 1;
	localparam int ALARM_IND_LINE = 0;

	localparam int RESET_TIME_MS = 60;
	localparam int CLK_KHZ       = 10000;

	typedef enum logic [1:0] {
		RUNNING  = 2'b01,
		RESETTING = 2'b10
	} phase_t;

	typedef struct packed {
		logic [6:0]  addr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        backup;
		logic        restore;
		logic        autonull;
		logic        selftest;
		logic        memtest;
	} cmd_t;

	typedef struct packed {
		phase_t      phase;
		logic [19:0] reset_count;
		logic [15:0] cmd;
		logic [15:0] io_line;
		logic [15:0] misc;
		logic [15:0] diag;
		logic [15:0] flash_count;
		logic [15:0] rdata;
		logic [3:0]  pin_s1;
		logic [3:0]  pin_s2;
		logic [3:0]  pin_s3;
		logic [3:0]  pin;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
		logic        soft_reset;
		cmd_t        busy;
	} state_t;

endpackage

/* sim/imu_tools_sva.sv */
// Assertions on the ports of the system-tool register bank.
`timescale 1ns/10ps
module imu_tools_sva
	import imu_tools_pkg::*;
#(
	parameter int RESET_CYCLES = 20
) (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire reg_req_t    i_req,
	input wire logic [15:0] o_rdata,
	input wire logic [3:0]  o_io_out,
	input wire logic [3:0]  o_io_oe,
	input wire logic        i_sample_tick,
	input wire cmd_t        i_done,
	input wire cmd_t        o_busy,
	input wire logic        o_soft_reset,
	input wire logic        o_lin_comp
);
	logic [19:0] hi_cnt;
	// Counts the cycles that the software reset stands.
	always_ff @(posedge i_clk) begin
		if (i_reset || !o_soft_reset)
			hi_cnt <= 20'h00000;
		else
			hi_cnt <= hi_cnt + 20'h00001;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_rd_diag;
		i_req.rd && i_req.addr == ADDR_DIAG && !i_sample_tick && i_done == '0;
	endsequence
	sequence s_quiet;
		!i_req.wr && !i_sample_tick && i_done == '0;
	endsequence
	sequence s_wr_cmd;
		i_req.wr && i_req.addr == ADDR_GLOBAL_CMD && !o_soft_reset;
	endsequence
	diag_clear_a: assert property (s_rd_diag ##1 s_quiet ##1 s_rd_diag
		|=> o_rdata == 16'h0000) else $error("flags survive read");
	misc_unused_a: assert property (i_req.rd && i_req.addr == ADDR_MISC
		|=> (o_rdata & ~MISC_MASK) == 16'h0000) else $error("misc unused set");
	backup_start_a: assert property (s_wr_cmd ##0 i_req.wdata[CMD_BACKUP]
		|=> o_busy.backup) else $error("backup not started");
	busy_drop_a: assert property (i_done.restore && o_busy.restore
		|=> ##[0:1] !o_busy.restore) else $error("restore stays busy");
	test_start_a: assert property (i_req.wr && i_req.addr == ADDR_MISC
		&& i_req.wdata[MISC_SELFTEST] && !o_soft_reset |=> o_busy.selftest)
		else $error("self-test not started");
	soft_start_a: assert property (s_wr_cmd ##0 i_req.wdata[CMD_SWRESET]
		|=> o_soft_reset) else $error("soft reset not started");
	soft_len_a: assert property ($fell(o_soft_reset) |-> hi_cnt >= RESET_CYCLES
		&& hi_cnt <= RESET_CYCLES + 1) else $error("soft reset length");
	lin_comp_a: assert property (i_req.wr && i_req.addr == ADDR_MISC
		&& !o_soft_reset |=> o_lin_comp == $past(i_req.wdata[MISC_LINCOMP]))
		else $error("lin comp wrong");
	undriven_a: assert property ((o_io_out & ~o_io_oe) == 4'h0)
		else $error("undriven line high");
endmodule
bind imu_system_tools_regs imu_tools_sva #(.RESET_CYCLES(RESET_CYCLES)) sva_inst (
	.i_clk, .i_reset, .i_req, .o_rdata, .o_io_out, .o_io_oe, .i_sample_tick,
	.i_done, .o_busy, .o_soft_reset, .o_lin_comp
);

/* sim/cmd_engine_model.sv */
// Model of the command engines that answer a running command with done.
`timescale 1ns/10ps
module cmd_engine_model
	import imu_tools_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_slow,
	input  wire cmd_t i_busy,
	output cmd_t      o_done
);
	logic [3:0] cnt;
	// A slow engine answers with done thirteen cycles after busy rises, a fast one three.
	always_ff @(posedge i_clk) begin
		o_done <= '0;
		if (i_busy == '0 || o_done != '0) begin
			cnt <= 4'h0;
		end else if (cnt == (i_slow ? 4'hC : 4'h2)) begin
			o_done <= i_busy;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

/* sim/tb.sv */
// Self-checking testbench of the system-tool register bank.
`timescale 1ns/10ps
module tb import imu_tools_pkg::*;;
	logic i_clk = 1'b0, i_reset = 1'b1, lclk = 1'b0, slow = 1'b0;
	logic i_data_ready = 1'b0, i_sample_tick = 1'b0, i_flash_write = 1'b0;
	logic i_selftest_error = 1'b0, i_checksum_fail = 1'b0;
	logic i_overrange = 1'b0, i_link_fail = 1'b0, i_flash_update_fail = 1'b0;
	logic [2:0] pins = 3'h0, i_alarm_indicator = 3'h0;
	logic [1:0] i_alarm_active = 2'h0;
	logic [5:0] i_selftest_fail = 6'h00;
	logic [3:0] o_io_out, o_io_oe;
	logic [15:0] o_rdata;
	logic o_soft_reset, o_lin_comp, o_accel_align;
	reg_req_t i_req = '0;
	cmd_t i_done, o_busy;
	int error_cnt = 0, check_count = 0;
	imu_system_tools_regs #(.RESET_CYCLES(20)) imu_system_tools_regs_inst (
		.i_clk, .i_reset, .i_req, .o_rdata, .i_io_in({lclk, pins}),
		.o_io_out, .o_io_oe, .i_data_ready, .i_sample_tick,
		.i_alarm_indicator, .i_alarm_active, .i_done, .i_selftest_fail,
		.i_selftest_error, .i_checksum_fail, .i_overrange, .i_link_fail,
		.i_flash_update_fail, .i_flash_write, .o_busy, .o_soft_reset,
		.o_lin_comp, .o_accel_align);
	cmd_engine_model cmd_engine_model_inst (
		.i_clk, .i_slow(slow), .i_busy(o_busy), .o_done(i_done));
	always #50 i_clk = ~i_clk;
	always #400 lclk = ~lclk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge i_clk) i_req <= '{a, 1'b1, 1'b0, d};
		@(posedge i_clk) i_req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge i_clk) i_req <= '{a, 1'b0, 1'b1, 16'h0000};
		@(posedge i_clk) i_req.rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	// The host keeps off the port until the command has finished.
	task automatic idle;
		for (int n = 0; n < 40 && o_busy !== '0; n++) @(posedge i_clk);
		#1 chk(16'(o_busy), 16'h0000);
	endtask
	task automatic tk;
		@(posedge i_clk) i_sample_tick <= 1'b1;
		@(posedge i_clk) i_sample_tick <= 1'b0;
	endtask
	task automatic t_ids;
		repeat (3) begin
			@(posedge i_clk) i_flash_write <= 1'b1;
			@(posedge i_clk) i_flash_write <= 1'b0;
		end
		rd(ADDR_FLASH_COUNT, 16'h0003);
		rd(ADDR_MISC, 16'h0006);
		rd(ADDR_DIAG, 16'h0000);
		rd(ADDR_LOT_FIRST, 16'h1111);
		rd(ADDR_LOT_SECOND, 16'h2222);
		rd(ADDR_PRODUCT, 16'h0001);
		rd(ADDR_SERIAL, 16'h0042);
		rd(7'h10, 16'h0000);
		chk(16'(o_io_oe), 16'h0001);
	endtask
	task automatic t_io;
		wr(ADDR_IO_LINE, 16'hF8FC);
		@(posedge i_clk) pins <= 3'h2;
		repeat (6) @(posedge i_clk);
		rd(ADDR_IO_LINE, 16'h0A0C);
		chk(16'(o_io_oe), 16'h000D);
		chk(16'(o_io_out), 16'h0008);
	endtask
	task automatic t_dready;
		@(posedge i_clk) i_alarm_indicator <= 3'h7;
		i_data_ready <= 1'b1;
		wr(ADDR_MISC, 16'hF3FF);
		@(posedge i_clk) #1 chk(16'(o_io_oe), 16'h000E);
		chk(16'(o_io_out), 16'h000A);
		chk(16'({o_lin_comp, o_accel_align}), 16'h0003);
		rd(ADDR_MISC, 16'h00C7);
		wr(ADDR_MISC, 16'h0004);
		@(posedge i_clk) #1 chk(16'(o_io_oe), 16'h000F);
		chk(16'(o_io_out), 16'h0008);
		@(posedge i_clk) i_data_ready <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1 chk(16'(o_io_out), 16'h0009);
	endtask
	task automatic t_cmds;
		logic [15:0] c [3] = '{16'h0008, 16'h0002, 16'h0001};
		logic [15:0] b [3] = '{16'h0010, 16'h0008, 16'h0004};
		wr(ADDR_GLOBAL_CMD, 16'hFF74);
		chk(16'(o_busy), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clk) slow <= i[0];
			wr(ADDR_GLOBAL_CMD, c[i]);
			chk(16'(o_busy), b[i]);
			idle();
			rd(ADDR_GLOBAL_CMD, 16'h0000);
		end
	endtask
	task automatic t_tests;
		@(posedge i_clk) i_selftest_fail <= 6'h2A;
		i_selftest_error <= 1'b1;
		i_checksum_fail <= 1'b1;
		wr(ADDR_MISC, 16'h0406);
		chk(16'(o_busy), 16'h0002);
		idle();
		rd(ADDR_MISC, 16'h0006);
		rd(ADDR_DIAG, 16'hA820);
		rd(ADDR_DIAG, 16'h0000);
		wr(ADDR_MISC, 16'h0806);
		chk(16'(o_busy), 16'h0001);
		idle();
		rd(ADDR_DIAG, 16'h0040);
	endtask
	task automatic t_flags;
		@(posedge i_clk) {i_overrange, i_link_fail} <= 2'h3;
		{i_flash_update_fail, i_alarm_active} <= 3'h7;
		tk();
		rd(ADDR_DIAG, 16'h031C);
		chk(16'(o_io_out), 16'h000A);
		rd(ADDR_DIAG, 16'h0000);
		tk();
		rd(ADDR_DIAG, 16'h031C);
		@(posedge i_clk) {i_overrange, i_link_fail} <= 2'h0;
		{i_flash_update_fail, i_alarm_active} <= 3'h0;
		tk();
		rd(ADDR_DIAG, 16'h0000);
	endtask
	task automatic t_swreset;
		wr(ADDR_MISC, 16'h00C6);
		wr(ADDR_GLOBAL_CMD, 16'h0080);
		chk(16'(o_soft_reset), 16'h0001);
		for (int n = 0; n < 40 && o_soft_reset !== 1'b0; n++) @(posedge i_clk);
		rd(ADDR_MISC, 16'h0006);
		chk(16'({o_lin_comp, o_accel_align}), 16'h0000);
	endtask
	// Line 4 follows the link clock, four cycles after each of its edges.
	task automatic t_link;
		@(negedge lclk);
		repeat (4) @(posedge i_clk);
		rd(ADDR_IO_LINE, 16'h0200);
		@(posedge lclk);
		repeat (4) @(posedge i_clk);
		rd(ADDR_IO_LINE, 16'h0A00);
	endtask
	task automatic report_and_stop;
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		t_ids();
		t_io();
		t_dready();
		t_cmds();
		t_tests();
		t_flags();
		t_swreset();
		t_link();
		report_and_stop();
	end
	initial begin
		#500000;
		error_cnt++;
		report_and_stop();
	end
endmodule
